// >>> rtl/tmx_pkg.sv
/*
  tmx_pkg: constants shared by the period timer and its self-checking bench.
  assumes: byte-wide registers on a 32-bit wishbone word, index-based map.
*/
package tmx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] TMX_IDX_COUNTER = 8'h11;
  localparam logic [7:0] TMX_IDX_CONTROL = 8'h12;
  localparam logic [7:0] TMX_IDX_LIMIT = 8'h92;
  localparam logic [7:0] TMX_IDX_STATUS = 8'h13;
  localparam logic [7:0] TMX_IDX_MASK = 8'h14;
  // reset values
  localparam logic [7:0] TMX_COUNTER_RST = 8'h00;
  localparam logic [7:0] TMX_LIMIT_RST = 8'hff;
  localparam logic [6:0] TMX_CONTROL_RST = 7'h00;
  // control field positions
  localparam int TMX_PRE_LSB = 0;
  localparam int TMX_RUN_BIT = 2;
  localparam int TMX_POST_LSB = 3;
  // flag position, shared by status and mask registers
  localparam int TMX_FLAG_BIT = 1;
  // instruction clock is the core clock divided by four
  localparam logic [1:0] TMX_INSTR_LAST = 2'h3;
  // prescaler terminal counts for 1:1, 1:4 and 1:16
  localparam logic [3:0] TMX_PRE_LAST_1 = 4'h0;
  localparam logic [3:0] TMX_PRE_LAST_4 = 4'h3;
  localparam logic [3:0] TMX_PRE_LAST_16 = 4'hf;
endpackage

// >>> rtl/tmx_scale_if.sv
/*
  tmx_scale_if: bundle between the timer and one scaler counter.
  assumes: one clock; owner drives tick, clear and terminal count.
*/
`timescale 1ns/100ps
interface tmx_scale_if;
  logic clr; // synchronous clear of the scaler count
  logic tick; // one-cycle input event
  logic [3:0] last; // terminal count, ratio minus one
  logic [3:0] count; // present count
  logic out; // one-cycle output event
  modport owner (output clr, output tick, output last,
                 input count, input out);
  modport scaler (input clr, input tick, input last,
                  output count, output out);
endinterface

// >>> rtl/tmx_scaler.sv
/*
  tmx_scaler: 4-bit divide-by-n event counter, used as pre and postscaler.
  assumes: tick is a one-cycle pulse in the clk_i domain.
*/
`timescale 1ns/100ps
module tmx_scaler (
  input wire logic clk_i,
  input wire logic rst_i,
  tmx_scale_if.scaler sc
);
  logic [3:0] cnt_q; // events seen since the last output

  // count events, wrap at the terminal count; clear wins over a tick
  always_ff @(posedge clk_i) begin
    if (rst_i || sc.clr) begin
      cnt_q <= 4'h0;
    end else if (sc.tick) begin
      if (cnt_q >= sc.last) begin
        // >= also recovers if the ratio shrank under a live count
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // output event on the tick that completes the ratio
  assign sc.out = sc.tick && !sc.clr && (cnt_q >= sc.last);
  assign sc.count = cnt_q;
endmodule

// >>> rtl/tmx_timer.sv
/*
  tmx_timer: 8-bit period timer with input prescaler and match postscaler,
  wishbone classic slave for its registers, one level interrupt.
  assumes: clk_i is the oscillator; rst_i covers every kind of reset;
  the serial port and pwm units sample the time base on clk_i.
*/
`timescale 1ns/100ps
module tmx_timer
  import tmx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic match_pulse_o,
  output logic [7:0] time_base_o,
  output logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus state
  logic ack_q; // answer to the pending request
  logic [31:0] dat_q; // read data captured with the answer
  logic req; // a request is on the bus
  logic commit; // edge at which the master sees ack
  logic [7:0] idx; // register index from the byte address
  logic wr_cnt; // write to the counter
  logic wr_ctl; // write to the control register
  logic wr_lim; // write to the limit register
  logic wr_sts; // write-one-to-clear on status
  logic wr_msk; // write to the mask register

  // timer state
  logic [1:0] inst_q; // oscillator-to-instruction divider
  logic inst_tick; // one pulse per instruction cycle
  logic [7:0] cnt_q; // period counter
  logic [7:0] lim_q; // period limit
  logic [6:0] ctl_q; // control; bit 7 is not stored
  logic flag_q; // sticky period match flag
  logic en_q; // period match interrupt enable
  logic irq_q; // registered interrupt level
  logic match_q; // registered match pulse
  logic run; // counter_run field
  logic [1:0] pre_sel; // input_divide_select field
  logic [3:0] post_sel; // match_divide_select field
  logic inc; // prescaled increment
  logic wrap; // increment that meets the limit

  tmx_scale_if pre_if ();
  tmx_scale_if post_if ();

  // map the two-bit select to the prescaler terminal count
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    logic [3:0] r;
    r = TMX_PRE_LAST_1;
    if (sel[1]) begin
      r = TMX_PRE_LAST_16;
    end else if (sel[0]) begin
      r = TMX_PRE_LAST_4;
    end
    return r;
  endfunction

  // bus decode; writes only land on the edge where ack is seen
  assign req = cyc_i && stb_i;
  assign commit = req && ack_q;
  assign idx = adr_i[9:2];
  assign wr_cnt = commit && we_i && sel_i[0] && (idx == TMX_IDX_COUNTER);
  assign wr_ctl = commit && we_i && sel_i[0] && (idx == TMX_IDX_CONTROL);
  assign wr_lim = commit && we_i && sel_i[0] && (idx == TMX_IDX_LIMIT);
  assign wr_sts = commit && we_i && sel_i[0] && (idx == TMX_IDX_STATUS);
  assign wr_msk = commit && we_i && sel_i[0] && (idx == TMX_IDX_MASK);

  // control fields
  assign run = ctl_q[TMX_RUN_BIT];
  assign pre_sel = ctl_q[TMX_PRE_LSB +: 2];
  assign post_sel = ctl_q[TMX_POST_LSB +: 4];

  // ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // read data is captured with ack; unmapped indices read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      unique case (idx)
        TMX_IDX_COUNTER: dat_q <= {24'h000000, cnt_q};
        TMX_IDX_CONTROL: dat_q <= {25'h0000000, ctl_q};
        TMX_IDX_LIMIT: dat_q <= {24'h000000, lim_q};
        TMX_IDX_STATUS: dat_q <= {30'h0, flag_q, 1'b0};
        TMX_IDX_MASK: dat_q <= {30'h0, en_q, 1'b0};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // instruction clock enable; free running so scaler clears stay exact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inst_q <= 2'h0;
    end else if (inst_q == TMX_INSTR_LAST) begin
      inst_q <= 2'h0;
    end else begin
      inst_q <= inst_q + 2'h1;
    end
  end
  assign inst_tick = (inst_q == TMX_INSTR_LAST);

  // prescaler: gated by run, ratio from the select field
  assign pre_if.tick = inst_tick && run;
  assign pre_if.last = pre_last(pre_sel);
  assign pre_if.clr = wr_cnt || wr_ctl;
  assign inc = pre_if.out;

  tmx_scaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sc(pre_if.scaler)
  );

  // postscaler: counts wraps, ratio is the field value plus one
  assign wrap = inc && (cnt_q == lim_q);
  assign post_if.tick = wrap;
  assign post_if.last = post_sel;
  assign post_if.clr = wr_cnt || wr_ctl;

  tmx_scaler u_post (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sc(post_if.scaler)
  );

  // period counter; software write beats an increment in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= TMX_COUNTER_RST;
    end else if (wr_cnt) begin
      cnt_q <= dat_i[7:0];
    end else if (wrap) begin
      cnt_q <= 8'h00;
    end else if (inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // period limit; a limit below the count lets it run to ff and roll over
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_q <= TMX_LIMIT_RST;
    end else if (wr_lim) begin
      lim_q <= dat_i[7:0];
    end
  end

  // control; the counter is untouched by this write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= TMX_CONTROL_RST;
    end else if (wr_ctl) begin
      ctl_q <= dat_i[6:0];
    end
  end

  // sticky flag; a set in the clearing cycle wins so no match is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (post_if.out) begin
      flag_q <= 1'b1;
    end else if (wr_sts && dat_i[TMX_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else if (wr_msk) begin
      en_q <= dat_i[TMX_FLAG_BIT];
    end
  end

  // registered outputs; one cycle behind their cause
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      irq_q <= flag_q && en_q;
      match_q <= wrap;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign irq_o = irq_q;
  assign match_pulse_o = match_q;
  assign time_base_o = cnt_q;

  // checks
  sequence seq_wrap;
    inc && (cnt_q == lim_q) && !wr_cnt;
  endsequence

  sequence seq_step;
    inc && (cnt_q != lim_q) && !wr_cnt;
  endsequence

  AST_WRAP: assert property (seq_wrap |=> cnt_q == 8'h00)
    else $error("counter did not return to zero after limit");
  AST_STEP: assert property (seq_step |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not advance by one");
  AST_PRE1: assert property ((pre_sel == 2'b00) && !pre_if.clr
      |-> inc == (inst_tick && run))
    else $error("divide by one prescaler missed a tick");
  AST_PRE16: assert property (pre_sel[1] |-> pre_if.last == 4'hf)
    else $error("divide by sixteen select mapped wrongly");
  AST_CNT_RST: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> cnt_q == 8'h00)
    else $error("counter not zero after reset");
  AST_LIM_RST: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> lim_q == 8'hff)
    else $error("limit not all ones after reset");
  // only the very next cycle is checked: software may clear after that
  AST_FLAG: assert property (post_if.out |=> flag_q)
    else $error("period match flag not set by postscaler");
  AST_POST: assert property (post_if.out |-> post_if.count == post_sel)
    else $error("postscaler fired at wrong count");
  AST_HOLD: assert property (!run && !wr_cnt |=> $stable(cnt_q))
    else $error("stopped counter moved");
  AST_CLR: assert property (wr_ctl || wr_cnt
      |=> pre_if.count == 4'h0 && post_if.count == 4'h0)
    else $error("scalers not cleared by write");
  AST_CTLW: assert property (wr_ctl |=> cnt_q == $past(cnt_q))
    else $error("control write changed the counter");
  AST_MATCH: assert property (seq_wrap |=> match_pulse_o ##1 !match_pulse_o)
    else $error("match pulse missing or too long");
  AST_IRQ: assert property (flag_q && en_q |=> irq_o)
    else $error("enabled flag did not raise interrupt");
  AST_NOIRQ: assert property (!en_q |=> !irq_o)
    else $error("interrupt raised while disabled");
  AST_B7: assert property (ack_o && idx == TMX_IDX_CONTROL
      |-> dat_o[7] == 1'b0)
    else $error("control bit 7 read as one");

  // bus timing: every request is answered once, one cycle later
  sequence seq_take;
    req && !ack_q;
  endsequence

  sequence seq_clear_flag;
    wr_sts && dat_i[TMX_FLAG_BIT] && !post_if.out;
  endsequence

  // answer comes in the cycle after the request is taken
  AST_ACK_REQ: assert property (seq_take |=> ack_o)
    else $error("request not answered in the next cycle");
  // ack is a single-cycle pulse, so a held request is not taken on two edges in a row
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  // software writes land in the register that was addressed
  AST_WR_CNT: assert property (wr_cnt |=> cnt_q == $past(dat_i[7:0]))
    else $error("counter write did not land");
  AST_WR_LIM: assert property (wr_lim |=> lim_q == $past(dat_i[7:0]))
    else $error("limit write did not land");

  // prescaler terminal count for the divide-by-four code
  AST_PRE4: assert property (pre_sel == 2'b01 |-> pre_if.last == 4'h3)
    else $error("divide by four select mapped wrongly");

  // a stopped timer produces no increments at all
  AST_RUN0: assert property (!run |-> !inc)
    else $error("increment seen while stopped");

  // the flag only falls on a write-one-to-clear
  AST_STICKY: assert property (flag_q && !wr_sts |=> flag_q)
    else $error("flag fell without a clear");
  // a clear with no competing set drops the flag
  AST_W1C: assert property (seq_clear_flag |=> !flag_q)
    else $error("write one did not clear the flag");

  // control register comes out of reset stopped with 1:1 scalers
  AST_CTL_RST: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> ctl_q == 7'h00)
    else $error("control not zero after reset");
endmodule

// >>> verification/period_timer_with_scalers_tb.sv
/*
  period_timer_with_scalers_tb: self-checking bench for tmx_timer.
  assumes: classic wishbone slave answering in a bounded time, register
  index times four as byte address, 25 MHz clock, synchronous reset.
*/
`timescale 1ns/100ps
module period_timer_with_scalers_tb;
  import tmx_pkg::*;
  logic clk_i = 1'b0; // core clock
  logic rst_i = 1'b1; // held high for ten cycles
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'hf; // only the low lane matters
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, match_pulse_o, irq_o;
  logic [7:0] time_base_o;
  logic [7:0] rd; // last read data
  logic [3:0] ps_list [3] = '{4'h0, 4'h1, 4'hf}; // postscale codes
  logic [3:0] ps; // postscale code under test
  int bad_count = 0, n_compared = 0, cycles = 0, n, gap, pulses;
  tmx_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .match_pulse_o(match_pulse_o), .time_base_o(time_base_o),
    .irq_o(irq_o));
  // free-running clock, 40 ns period
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // hang guard: the whole run needs under two thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] idx, input logic wr,
                    input logic [7:0] wd);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, wd};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k == 50) begin
      bad_count++;
      $display("CHECK FAILED ack expected 1 seen %b", ack_o);
    end
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] idx,
                        input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    check(name, exp, rd);
  endtask
  // wait for a match pulse under a bound, sampling before each edge
  task automatic wait_pulse();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (match_pulse_o !== 1'b1 && n < 2000);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values
    rd_chk("counter rst", TMX_IDX_COUNTER, 8'h00);
    rd_chk("control rst", TMX_IDX_CONTROL, 8'h00);
    rd_chk("limit rst", TMX_IDX_LIMIT, 8'hff);
    rd_chk("status rst", TMX_IDX_STATUS, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    // access kinds: bit 7 of control is not implemented
    wb(TMX_IDX_CONTROL, 1'b1, 8'hfb);
    rd_chk("control rw", TMX_IDX_CONTROL, 8'h7b);
    wb(TMX_IDX_COUNTER, 1'b1, 8'h05);
    rd_chk("counter rw", TMX_IDX_COUNTER, 8'h05);
    // control write with timer stopped keeps the counter
    wb(TMX_IDX_CONTROL, 1'b1, 8'h01);
    rd_chk("counter kept", TMX_IDX_COUNTER, 8'h05);
    rd_chk("stopped hold", TMX_IDX_COUNTER, 8'h05);
    wb(TMX_IDX_LIMIT, 1'b1, 8'h02);
    rd_chk("limit rw", TMX_IDX_LIMIT, 8'h02);
    wb(TMX_IDX_COUNTER, 1'b1, 8'h00);
    // every prescale code: pulse spacing is 4 * pre * (limit + 1)
    for (int p = 0; p < 4; p++) begin
      wb(TMX_IDX_CONTROL, 1'b1, {6'h01, p[1:0]});
      wait_pulse();
      check("wrap value", 8'h00, time_base_o);
      wait_pulse();
      gap = (p == 0) ? 12 : (p == 1) ? 48 : 192;
      check("pulse gap", gap[7:0], n[7:0]);
    end
    // postscale codes: flag after field + 1 matches
    wb(TMX_IDX_MASK, 1'b1, 8'h02);
    for (int i = 0; i < 3; i++) begin
      ps = ps_list[i];
      wb(TMX_IDX_CONTROL, 1'b1, 8'h00);
      wb(TMX_IDX_STATUS, 1'b1, 8'h02);
      wb(TMX_IDX_CONTROL, 1'b1, {1'b0, ps, 3'h4});
      pulses = 0;
      n = 0;
      // irq lags the flag a clock, far inside one 12-clock period
      while (irq_o !== 1'b1 && n < 400) begin
        @(posedge clk_i);
        n++;
        if (match_pulse_o === 1'b1) pulses++;
      end
      check("post ratio", {4'h0, ps} + 8'h01, pulses[7:0]);
    end
    // flag sticks with the timer stopped; enable gates the request
    wb(TMX_IDX_CONTROL, 1'b1, 8'h00);
    rd_chk("flag sticky", TMX_IDX_STATUS, 8'h02);
    check("irq level", 8'h01, {7'h00, irq_o});
    wb(TMX_IDX_MASK, 1'b1, 8'h00);
    rd_chk("mask off", TMX_IDX_MASK, 8'h00);
    check("irq masked", 8'h00, {7'h00, irq_o});
    wb(TMX_IDX_MASK, 1'b1, 8'h02);
    wb(TMX_IDX_STATUS, 1'b1, 8'h02);
    rd_chk("flag clear", TMX_IDX_STATUS, 8'h00);
    check("irq clear", 8'h00, {7'h00, irq_o});
    // counter write clears the prescaler: first step after full ratio
    wb(TMX_IDX_CONTROL, 1'b1, 8'h05);
    wb(TMX_IDX_COUNTER, 1'b1, 8'h01);
    wait_pulse();
    check("after clear", 8'h00, time_base_o);
    end_of_test();
  end
endmodule
